//--- inc/rx_slot_alloc_pkg.sv
// Constants and carriers for the receive port/time-slot allocation bank.
// Assumes a single 125 MHz clock and a plain strobe register port.
package rx_slot_alloc_pkg;
  localparam int unsigned NUM_PORTS   = 32;
  localparam int unsigned NUM_GROUPS  = 32;
  localparam int unsigned PORT_IDX_W  = 5;
  localparam int unsigned PTR_W       = 13;
  localparam int unsigned LEN_W       = 6;
  localparam int unsigned ADDR_W      = 12;
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned DS0_PORTS   = 12;

  // Bank bases (byte addresses); each bank holds one word per index
  localparam logic [ADDR_W-1:0] SLOT_PTR_BASE   = 12'h000;
  localparam logic [ADDR_W-1:0] GROUP_PTR_BASE  = 12'h100;
  localparam logic [ADDR_W-1:0] GROUP_STATE_BASE = 12'h200;
  localparam logic [ADDR_W-1:0] PORT_CFG_BASE   = 12'h300;
  localparam logic [ADDR_W-1:0] BANK_MASK       = 12'hf00;
  localparam logic [1:0]        WORD_ALIGN      = 2'h0;
  localparam int unsigned       BANK_LSB        = 8;

  // Slot pointer allocation word
  localparam int unsigned LAST_PTR_LSB  = 16;
  localparam int unsigned FIRST_PTR_LSB = 0;
  // Group pointer word
  localparam int unsigned GRP_FIRST_LSB = 6;
  localparam int unsigned GRP_LEN_LSB   = 0;
  // Group state word
  localparam int unsigned GRP_STATE_LSB = 0;
  // Port configuration word
  localparam int unsigned GLOBAL_FRAME_SYNC_EDGE_BIT = 14;
  localparam int unsigned PORT_ON_BIT    = 13;
  localparam int unsigned KIND_LSB       = 9;
  localparam int unsigned SYNC_EDGE_BIT  = 5;
  localparam int unsigned DATA_EDGE_BIT  = 4;
  localparam int unsigned OOF_EDGE_BIT   = 3;
  localparam int unsigned OOF_ABT_BIT    = 2;
  localparam int unsigned OOF_IEN_BIT    = 1;
  localparam int unsigned COFA_IEN_BIT   = 0;

  localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [PTR_W-1:0]  ONE_PTR   = 13'h0001;

  typedef enum logic [2:0] {
    KIND_UNCHAN  = 3'h0,
    KIND_T1      = 3'h1,
    KIND_NX2     = 3'h2,
    KIND_NX3     = 3'h3,
    KIND_NX4     = 3'h4,
    KIND_NXN     = 3'h5,
    KIND_SLOTBUS = 3'h6,
    KIND_RSVD    = 3'h7
  } rx_port_kind_t;

  typedef enum logic [1:0] {
    GRP_DISABLED = 2'h0,
    GRP_ENABLED  = 2'h1,
    GRP_POLLING  = 2'h2,
    GRP_RSVD     = 2'h3
  } group_state_t;

  typedef struct packed {
    logic [PTR_W-1:0] rx_last_slot_pointer;
    logic [PTR_W-1:0] rx_first_slot_pointer;
  } slot_alloc_t;

  typedef struct packed {
    logic [PTR_W-1:0] rx_group_first_slot;
    logic [LEN_W-1:0] rx_group_slot_count;
  } group_alloc_t;

  typedef struct packed {
    logic          rx_global_sync_sample_edge;
    logic          rx_port_on;
    rx_port_kind_t rx_port_kind_field;
    logic          sync_edge;
    logic          data_edge;
    logic          oof_edge;
    logic          oof_abort;
    logic          oof_irq_en;
    logic          cofa_irq_en;
  } port_cfg_t;

  // Register port request
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_t;

  // Query from the serial interface: which port, which map entry
  typedef struct packed {
    logic [PORT_IDX_W-1:0] port;
    logic [PTR_W-1:0]      entry;
    logic                  slot_en;
    logic                  ds0;
  } slot_query_t;

  typedef struct packed {
    logic             in_port;
    logic             active;
    logic             ds0_ok;
    logic [PTR_W-1:0] slot_total;
  } slot_answer_t;
endpackage

//--- hdl/rx_slot_window.sv
// Decides whether a time-slot map entry belongs to a port and is live.
// Assumes the caller supplies that port's registered configuration.
`timescale 1ns/100ps
`default_nettype none
module rx_slot_window (
  input  wire rx_slot_alloc_pkg::slot_alloc_t  i_alloc,
  input  wire rx_slot_alloc_pkg::port_cfg_t    i_cfg,
  input  wire logic                            i_ds0_capable,
  input  wire rx_slot_alloc_pkg::slot_query_t  i_query,
  output rx_slot_alloc_pkg::slot_answer_t      o_answer
);
  logic [rx_slot_alloc_pkg::PTR_W-1:0] first_ptr;
  logic [rx_slot_alloc_pkg::PTR_W-1:0] last_ptr;
  logic                                unchan;

  assign first_ptr = i_alloc.rx_first_slot_pointer;
  assign last_ptr  = i_alloc.rx_last_slot_pointer;
  assign unchan    = i_cfg.rx_port_kind_field ==
                     rx_slot_alloc_pkg::KIND_UNCHAN;

  always_comb begin
    o_answer = '0;
    if (unchan) begin
      // Last pointer is free for other use in this kind
      o_answer.in_port    = i_query.entry == first_ptr; // [R6]
      o_answer.slot_total = rx_slot_alloc_pkg::ONE_PTR; // [R6]
    end else begin
      o_answer.in_port    = (i_query.entry >= first_ptr) &&
                            (i_query.entry <= last_ptr);
      // Count is end minus start, wrapped to pointer width
      o_answer.slot_total = last_ptr - first_ptr; // [R2]
    end
    // Port enable gates every slot enable; no map contents change
    o_answer.active = o_answer.in_port && i_cfg.rx_port_on &&
                      i_query.slot_en; // [R14] [R15]
    o_answer.ds0_ok = o_answer.in_port && i_query.ds0 && i_ds0_capable &&
                      (i_cfg.rx_port_kind_field ==
                       rx_slot_alloc_pkg::KIND_SLOTBUS); // [R17]
  end
endmodule
`default_nettype wire

//--- hdl/rx_timeslot_port_alloc.sv
// Per-port receive allocation bank: slot pointers, group pointers,
// group states and port configuration, plus a slot membership query.
// Assumes one clock, and a register master that never overlaps strobes.
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// [R1] Each of 32 ports owns one slot pointer word: start and end.
// [R2] Slots allocated to a port equal end pointer minus start pointer.
// [R3] Software sets unchannelized kind when both pointers are equal.
// [R4] Software sets kind 5, or 1 for T1, for two or more slots.
// [R5] Slot bus ports need over eight slots and the slot bus kind.
// [R6] Unchannelized ports use only the start entry; end pointer ignored.
// [R7] Slot word: end pointer 28:16, start pointer 12:0, rest reserved.
// [R8] Group word bits 18:6 hold the group's first map location.
// [R9] Group word bits 5:0 hold slot count minus one.
// [R10] Software zeroes group states of a port before enabling it.
// [R11] One state word per group at state base plus group number.
// [R12] State field 1:0: disabled, enabled, polling, reserved; device updates.
// [R13] Each port has one receive configuration word.
// [R14] Port enable clear makes all its slots inactive; descriptors untouched.
// [R15] With port enabled, slot active only if its own enable set.
// [R16] Kind field 11:9: unchannelized, T1, Nx64 variants, slot bus.
// [R17] Kind 6 is slot bus; first twelve ports may extract DS0.
// [R18] Reserved bits are ignored by the device and read as zero.
module rx_timeslot_port_alloc (
  input  wire logic                                i_ref_clk,
  input  wire logic                                i_arst_n,
  input  wire logic [rx_slot_alloc_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [rx_slot_alloc_pkg::DATA_W-1:0] i_wdata,
  input  wire logic                                i_wr,
  input  wire logic                                i_rd,
  output logic [rx_slot_alloc_pkg::DATA_W-1:0]      o_rdata,
  input  wire rx_slot_alloc_pkg::slot_query_t       i_query,
  output rx_slot_alloc_pkg::slot_answer_t           o_answer,
  input  wire logic                                i_grp_upd,
  input  wire logic [rx_slot_alloc_pkg::PORT_IDX_W-1:0] i_grp_idx,
  input  wire rx_slot_alloc_pkg::group_state_t      i_grp_state,
  output rx_slot_alloc_pkg::group_alloc_t           o_grp_alloc,
  output rx_slot_alloc_pkg::group_state_t           o_grp_state,
  output logic [rx_slot_alloc_pkg::NUM_PORTS-1:0]   o_port_on
);
  localparam int unsigned NP = rx_slot_alloc_pkg::NUM_PORTS;
  localparam int unsigned NG = rx_slot_alloc_pkg::NUM_GROUPS;
  localparam int unsigned IW = rx_slot_alloc_pkg::PORT_IDX_W;

  typedef enum logic [1:0] {
    BANK_SLOT  = 2'h0,
    BANK_GRP   = 2'h1,
    BANK_STATE = 2'h3,
    BANK_CFG   = 2'h2
  } bank_t;

  rx_slot_alloc_pkg::slot_alloc_t  slot_reg  [NP];
  rx_slot_alloc_pkg::group_alloc_t grp_reg   [NG];
  rx_slot_alloc_pkg::group_state_t state_reg [NG];
  rx_slot_alloc_pkg::port_cfg_t    cfg_reg   [NP];
  logic [rx_slot_alloc_pkg::DATA_W-1:0] rdata_next;
  logic [rx_slot_alloc_pkg::DATA_W-1:0] rdata_reg;
  logic                                 hit;
  bank_t                                bank;
  logic [IW-1:0]                        idx;

  // Decode one access into bank and word index; returns hit
  function automatic logic decode(
    input  logic [rx_slot_alloc_pkg::ADDR_W-1:0] a,
    output bank_t                                b,
    output logic [IW-1:0]                        i
  );
    logic [rx_slot_alloc_pkg::ADDR_W-1:0] base;
    logic [rx_slot_alloc_pkg::ADDR_W-1:0] off;
    base = a & rx_slot_alloc_pkg::BANK_MASK;
    off  = a & ~rx_slot_alloc_pkg::BANK_MASK;
    i    = off[IW+1:2];
    b    = BANK_SLOT;
    decode = (a[1:0] == rx_slot_alloc_pkg::WORD_ALIGN) &&
             (off[rx_slot_alloc_pkg::BANK_LSB-1:IW+2] == '0);
    unique case (base)
      rx_slot_alloc_pkg::SLOT_PTR_BASE:    b = BANK_SLOT;
      rx_slot_alloc_pkg::GROUP_PTR_BASE:   b = BANK_GRP;
      rx_slot_alloc_pkg::GROUP_STATE_BASE: b = BANK_STATE;
      rx_slot_alloc_pkg::PORT_CFG_BASE:    b = BANK_CFG;
      default:                             decode = 1'b0;
    endcase
  endfunction

  always_comb begin
    hit = decode(i_addr, bank, idx);
  end

  // Slot pointer words, one per port
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (int p = 0; p < NP; p++) begin
        slot_reg[p] <= '0; // [R1]
      end
    end else if (i_wr && hit && bank == BANK_SLOT) begin
      slot_reg[idx].rx_last_slot_pointer <= i_wdata[
        rx_slot_alloc_pkg::LAST_PTR_LSB +: rx_slot_alloc_pkg::PTR_W]; // [R7]
      slot_reg[idx].rx_first_slot_pointer <= i_wdata[
        rx_slot_alloc_pkg::FIRST_PTR_LSB +: rx_slot_alloc_pkg::PTR_W]; // [R7]
    end
  end

  // Group pointer words
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (int g = 0; g < NG; g++) begin
        grp_reg[g] <= '0;
      end
    end else if (i_wr && hit && bank == BANK_GRP) begin
      grp_reg[idx].rx_group_first_slot <= i_wdata[
        rx_slot_alloc_pkg::GRP_FIRST_LSB +: rx_slot_alloc_pkg::PTR_W]; // [R8]
      grp_reg[idx].rx_group_slot_count <= i_wdata[
        rx_slot_alloc_pkg::GRP_LEN_LSB +: rx_slot_alloc_pkg::LEN_W]; // [R9]
    end
  end

  // Group states: the receive engine's update wins over a software write
  // to the same word, so an internal transition is never lost.
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (int g = 0; g < NG; g++) begin
        state_reg[g] <= rx_slot_alloc_pkg::GRP_DISABLED;
      end
    end else begin
      if (i_wr && hit && bank == BANK_STATE) begin
        state_reg[idx] <= rx_slot_alloc_pkg::group_state_t'(
          i_wdata[rx_slot_alloc_pkg::GRP_STATE_LSB +: 2]); // [R11] [R12]
      end
      if (i_grp_upd) begin
        state_reg[i_grp_idx] <= i_grp_state; // [R12]
      end
    end
  end

  // Port configuration words
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (int p = 0; p < NP; p++) begin
        cfg_reg[p] <= '0;
      end
    end else if (i_wr && hit && bank == BANK_CFG) begin
      cfg_reg[idx].rx_global_sync_sample_edge <=
        i_wdata[rx_slot_alloc_pkg::GLOBAL_FRAME_SYNC_EDGE_BIT]; // [R13]
      cfg_reg[idx].rx_port_on <= i_wdata[rx_slot_alloc_pkg::PORT_ON_BIT];
      cfg_reg[idx].rx_port_kind_field <= rx_slot_alloc_pkg::rx_port_kind_t'(
        i_wdata[rx_slot_alloc_pkg::KIND_LSB +: 3]); // [R16]
      cfg_reg[idx].sync_edge   <= i_wdata[rx_slot_alloc_pkg::SYNC_EDGE_BIT];
      cfg_reg[idx].data_edge   <= i_wdata[rx_slot_alloc_pkg::DATA_EDGE_BIT];
      cfg_reg[idx].oof_edge    <= i_wdata[rx_slot_alloc_pkg::OOF_EDGE_BIT];
      cfg_reg[idx].oof_abort   <= i_wdata[rx_slot_alloc_pkg::OOF_ABT_BIT];
      cfg_reg[idx].oof_irq_en  <= i_wdata[rx_slot_alloc_pkg::OOF_IEN_BIT];
      cfg_reg[idx].cofa_irq_en <= i_wdata[rx_slot_alloc_pkg::COFA_IEN_BIT];
    end
  end

  // Read mux; reserved bits and unmapped addresses return zero
  always_comb begin
    rdata_next = rx_slot_alloc_pkg::ZERO_WORD;
    if (i_rd && hit) begin
      unique case (bank)
        BANK_SLOT: begin
          rdata_next[rx_slot_alloc_pkg::LAST_PTR_LSB +:
                     rx_slot_alloc_pkg::PTR_W] =
            slot_reg[idx].rx_last_slot_pointer;
          rdata_next[rx_slot_alloc_pkg::FIRST_PTR_LSB +:
                     rx_slot_alloc_pkg::PTR_W] =
            slot_reg[idx].rx_first_slot_pointer; // [R18]
        end
        BANK_GRP: begin
          rdata_next[rx_slot_alloc_pkg::GRP_FIRST_LSB +:
                     rx_slot_alloc_pkg::PTR_W] =
            grp_reg[idx].rx_group_first_slot;
          rdata_next[rx_slot_alloc_pkg::GRP_LEN_LSB +:
                     rx_slot_alloc_pkg::LEN_W] =
            grp_reg[idx].rx_group_slot_count;
        end
        BANK_STATE: begin
          rdata_next[rx_slot_alloc_pkg::GRP_STATE_LSB +: 2] = state_reg[idx];
        end
        BANK_CFG: begin
          rdata_next[rx_slot_alloc_pkg::GLOBAL_FRAME_SYNC_EDGE_BIT] =
            cfg_reg[idx].rx_global_sync_sample_edge;
          rdata_next[rx_slot_alloc_pkg::PORT_ON_BIT] = cfg_reg[idx].rx_port_on;
          rdata_next[rx_slot_alloc_pkg::KIND_LSB +: 3] =
            cfg_reg[idx].rx_port_kind_field;
          rdata_next[rx_slot_alloc_pkg::SYNC_EDGE_BIT] =
            cfg_reg[idx].sync_edge;
          rdata_next[rx_slot_alloc_pkg::DATA_EDGE_BIT] =
            cfg_reg[idx].data_edge;
          rdata_next[rx_slot_alloc_pkg::OOF_EDGE_BIT] =
            cfg_reg[idx].oof_edge;
          rdata_next[rx_slot_alloc_pkg::OOF_ABT_BIT] =
            cfg_reg[idx].oof_abort;
          rdata_next[rx_slot_alloc_pkg::OOF_IEN_BIT] =
            cfg_reg[idx].oof_irq_en;
          rdata_next[rx_slot_alloc_pkg::COFA_IEN_BIT] =
            cfg_reg[idx].cofa_irq_en;
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rdata_reg <= rx_slot_alloc_pkg::ZERO_WORD;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign o_rdata = rdata_reg;

  // Group lookup for the receive engine, indexed like the state update
  assign o_grp_alloc = grp_reg[i_grp_idx];
  assign o_grp_state = state_reg[i_grp_idx];

  genvar gp;
  generate
    for (gp = 0; gp < NP; gp++) begin : g_on
      assign o_port_on[gp] = cfg_reg[gp].rx_port_on; // [R14]
    end
  endgenerate

  // DS0 extraction exists only on the low-numbered ports
  logic ds0_capable;
  assign ds0_capable = i_query.port <
                       IW'(rx_slot_alloc_pkg::DS0_PORTS); // [R17]

  rx_slot_window u_window (
    .i_alloc       (slot_reg[i_query.port]),
    .i_cfg         (cfg_reg[i_query.port]),
    .i_ds0_capable (ds0_capable),
    .i_query       (i_query),
    .o_answer      (o_answer)
  );
endmodule
`default_nettype wire

//--- bench/rx_alloc_checker.sv
// Port-level checker for the receive allocation bank.
// Assumes it is bound onto rx_timeslot_port_alloc; one clock domain.
`timescale 1ns/100ps
`default_nettype none
module rx_alloc_checker (
  input wire logic                              i_ref_clk,
  input wire logic                              i_arst_n,
  input wire logic [11:0]                       i_addr,
  input wire logic [31:0]                       i_wdata,
  input wire logic                              i_wr,
  input wire logic                              i_rd,
  input wire logic [31:0]                       o_rdata,
  input wire rx_slot_alloc_pkg::slot_query_t    i_query,
  input wire rx_slot_alloc_pkg::slot_answer_t   o_answer,
  input wire logic                              i_grp_upd,
  input wire logic [4:0]                        i_grp_idx,
  input wire rx_slot_alloc_pkg::group_state_t   i_grp_state,
  input wire rx_slot_alloc_pkg::group_alloc_t   o_grp_alloc,
  input wire rx_slot_alloc_pkg::group_state_t   o_grp_state,
  input wire logic [31:0]                       o_port_on
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);

  property p_rd_idle;
    !i_rd |=> o_rdata == 32'h0000_0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");

  property p_slot_resv;
    i_rd && i_addr[11:8] == 4'h0 |=>
      o_rdata[31:29] == 3'h0 && o_rdata[15:13] == 3'h0;
  endproperty
  a_slot_resv: assert property (p_slot_resv)
    else $error("slot word resv");

  property p_grp_resv;
    i_rd && i_addr[11:8] == 4'h1 |=> o_rdata[31:19] == 13'h0000;
  endproperty
  a_grp_resv: assert property (p_grp_resv)
    else $error("group word resv");

  property p_state_resv;
    i_rd && i_addr[11:8] == 4'h2 |=> o_rdata[31:2] == 30'h0000_0000;
  endproperty
  a_state_resv: assert property (p_state_resv)
    else $error("state resv");

  property p_cfg_resv;
    i_rd && i_addr[11:8] == 4'h3 |=> o_rdata[31:15] == 17'h0_0000 &&
      o_rdata[12] == 1'b0 && o_rdata[8:6] == 3'h0;
  endproperty
  a_cfg_resv: assert property (p_cfg_resv)
    else $error("cfg resv");

  property p_active;
    o_answer.active |-> o_answer.in_port && i_query.slot_en &&
      o_port_on[i_query.port];
  endproperty
  a_active: assert property (p_active)
    else $error("active without cause");

  property p_off_idle;
    !o_port_on[i_query.port] |-> !o_answer.active;
  endproperty
  a_off_idle: assert property (p_off_idle)
    else $error("disabled port live");

  property p_ds0;
    o_answer.ds0_ok |->
      i_query.ds0 && o_answer.in_port && i_query.port < 5'd12;
  endproperty
  a_ds0: assert property (p_ds0)
    else $error("ds0 outside first ports");

  property p_port_on;
    i_wr && i_addr[11:8] == 4'h3 && i_addr[7] == 1'b0 && i_addr[1:0] == 2'h0
      |=> o_port_on[$past(i_addr[6:2])] == $past(i_wdata[13]);
  endproperty
  a_port_on: assert property (p_port_on)
    else $error("port enable lost");

  property p_grp_upd;
    i_grp_upd |=> i_grp_idx != $past(i_grp_idx) ||
      o_grp_state == $past(i_grp_state);
  endproperty
  a_grp_upd: assert property (p_grp_upd)
    else $error("state not updated");

  c_cfg_rd: cover property (i_rd && i_addr[11:8] == 4'h3);
  c_active: cover property (o_answer.active);
  c_ds0: cover property (o_answer.ds0_ok);
endmodule

bind rx_timeslot_port_alloc rx_alloc_checker u_chk (
  .i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_query(i_query), .o_answer(o_answer), .i_grp_upd(i_grp_upd),
  .i_grp_idx(i_grp_idx), .i_grp_state(i_grp_state),
  .o_grp_alloc(o_grp_alloc), .o_grp_state(o_grp_state),
  .o_port_on(o_port_on)
);
`default_nettype wire

//--- bench/testbench.sv
// Self-checking bench for the receive allocation bank.
// Assumes the plain strobe register port and combinational slot query.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic                                i_ref_clk;
  logic                                i_arst_n;
  logic [11:0]                         i_addr;
  logic [31:0]                         i_wdata;
  logic                                i_wr;
  logic                                i_rd;
  logic [31:0]                         o_rdata;
  rx_slot_alloc_pkg::slot_query_t      i_query;
  rx_slot_alloc_pkg::slot_answer_t     o_answer;
  logic                                i_grp_upd;
  logic [4:0]                          i_grp_idx;
  rx_slot_alloc_pkg::group_state_t     i_grp_state;
  rx_slot_alloc_pkg::group_alloc_t     o_grp_alloc;
  rx_slot_alloc_pkg::group_state_t     o_grp_state;
  logic [31:0]                         o_port_on;
  int                                  err_total;
  int                                  checks;

  rx_timeslot_port_alloc dut (
    .i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_query(i_query), .o_answer(o_answer), .i_grp_upd(i_grp_upd),
    .i_grp_idx(i_grp_idx), .i_grp_state(i_grp_state),
    .o_grp_alloc(o_grp_alloc), .o_grp_state(o_grp_state),
    .o_port_on(o_port_on)
  );

  initial begin
    i_ref_clk = 1'b0;
    forever #4 i_ref_clk = ~i_ref_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    @(posedge i_ref_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 chk(o_rdata, exp);
  endtask

  task automatic q(input logic [4:0] p, input logic [12:0] e,
                   input logic en, input logic ds0,
                   input logic [15:0] m, input logic [15:0] exp);
    @(posedge i_ref_clk);
    i_query <= {p, e, en, ds0};
    #1 chk({16'h0000, o_answer & m}, {16'h0000, exp});
  endtask

  task automatic done(input string name);
    $display("test %s finished, mismatches so far %0d", name, err_total);
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    #100000;
    err_total++;
    end_of_test;
  end

  initial begin
    err_total = 0;
    checks = 0;
    i_arst_n = 1'b0;
    i_addr = 12'h000;
    i_wdata = 32'h0000_0000;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_query = '0;
    i_grp_upd = 1'b0;
    i_grp_idx = 5'h00;
    i_grp_state = rx_slot_alloc_pkg::GRP_DISABLED;
    repeat (5) @(posedge i_ref_clk);
    i_arst_n <= 1'b1;
    rd(12'h304, 32'h0000_0000);
    rd(12'h07c, 32'h0000_0000);
    chk(o_port_on, 32'h0000_0000);
    done("reset");
    wr(12'h07c, 32'hffff_ffff);
    rd(12'h07c, 32'h1fff_1fff);
    wr(12'h11c, 32'hffff_ffff);
    rd(12'h11c, 32'h0007_ffff);
    @(posedge i_ref_clk);
    i_grp_idx <= 5'h07;
    #1 chk({13'h0000, o_grp_alloc}, 32'h0007_ffff);
    wr(12'h37c, 32'hffff_ffff);
    rd(12'h37c, 32'h0000_6e3f);
    chk(o_port_on, 32'h8000_0000);
    wr(12'h080, 32'h0000_1234);
    rd(12'h080, 32'h0000_0000);
    wr(12'h400, 32'h0000_1234);
    rd(12'h400, 32'h0000_0000);
    done("fields");
    i_grp_idx <= 5'h02;
    for (int s = 0; s < 4; s++) begin
      wr(12'h208, 32'hffff_fffc | 32'(s));
      rd(12'h208, 32'(s));
      chk({30'h0, o_grp_state}, 32'(s));
    end
    @(posedge i_ref_clk);
    i_grp_upd <= 1'b1;
    i_grp_idx <= 5'h05;
    i_grp_state <= rx_slot_alloc_pkg::GRP_POLLING;
    @(posedge i_ref_clk);
    i_grp_upd <= 1'b0;
    rd(12'h214, 32'h0000_0002);
    rd(12'h208, 32'h0000_0003);
    // Engine update and software write to one group in the same cycle
    @(posedge i_ref_clk);
    i_wr <= 1'b1;
    i_addr <= 12'h214;
    i_wdata <= 32'h0000_0001;
    i_grp_upd <= 1'b1;
    i_grp_state <= rx_slot_alloc_pkg::GRP_DISABLED;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
    i_grp_upd <= 1'b0;
    rd(12'h214, 32'h0000_0000);
    wr(12'h208, 32'h0000_0000);
    rd(12'h208, 32'h0000_0000);
    done("group state");
    wr(12'h00c, 32'h0014_000a);
    wr(12'h030, 32'h0014_000a);
    wr(12'h30c, 32'h0000_2a00);
    q(5'd3, 13'd15, 1'b1, 1'b0, 16'hffff, 16'hc00a);
    q(5'd3, 13'd15, 1'b0, 1'b0, 16'hffff, 16'h800a);
    q(5'd3, 13'd21, 1'b1, 1'b0, 16'he000, 16'h0000);
    q(5'd3, 13'd15, 1'b1, 1'b1, 16'he000, 16'hc000);
    wr(12'h30c, 32'h0000_0a00);
    q(5'd3, 13'd15, 1'b1, 1'b0, 16'hffff, 16'h800a);
    rd(12'h00c, 32'h0014_000a);
    wr(12'h30c, 32'h0000_2000);
    q(5'd3, 13'd10, 1'b1, 1'b0, 16'hffff, 16'hc001);
    q(5'd3, 13'd15, 1'b1, 1'b0, 16'he000, 16'h0000);
    wr(12'h010, 32'h0005_0005);
    wr(12'h310, 32'h0000_2000);
    q(5'd4, 13'd5, 1'b1, 1'b0, 16'hffff, 16'hc001);
    wr(12'h30c, 32'h0000_2c00);
    wr(12'h330, 32'h0000_2c00);
    q(5'd3, 13'd15, 1'b1, 1'b1, 16'hffff, 16'he00a);
    q(5'd12, 13'd15, 1'b1, 1'b1, 16'hffff, 16'hc00a);
    chk(o_port_on, 32'h8000_1018);
    done("query");
    end_of_test;
  end
endmodule
`default_nettype wire
